//--- design/rsmu_core.sv
// rotate, shift and mask datapath with its small register port
// assumes decode holds operands stable with op_valid_in for one cycle
//
// Our own choices: the register addresses and strobed register access.
`include "rsmu_cfg.svh"
module rsmu_core (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic op_valid_in,
  input wire rsmu_pkg::rsmu_op_e op_code_in,
  input wire logic [`RSMU_W-1:0] source_gpr_in,
  input wire logic [`RSMU_W-1:0] amount_gpr_in,
  input wire logic [`RSMU_CNT_W-1:0] imm_count_in,
  input wire logic [`RSMU_CNT_W-1:0] mask_begin_in,
  input wire logic [`RSMU_CNT_W-1:0] mask_end_in,
  input wire logic record_bit_in,
  output logic op_ready_out,
  output logic [`RSMU_W-1:0] dest_gpr_out,
  output logic dest_wr_out,
  output logic [3:0] cond_field_zero_out,
  output logic cond_wr_out,
  output logic algebraic_out_flag_out,
  output logic carry_wr_out,
  input wire logic [`RSMU_AW-1:0] reg_addr_in,
  input wire logic [`RSMU_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`RSMU_W-1:0] reg_rdata_out
);
  import rsmu_pkg::*;

  rsmu_state_s st_reg;
  rsmu_state_s st_next;
  logic op_fire;
  logic [`RSMU_CNT_W-1:0] amt_lo;
  logic amt_kill;
  logic [`RSMU_CNT_W-1:0] rot_n;
  logic [`RSMU_CNT_W-1:0] mb_sel;
  logic [`RSMU_CNT_W-1:0] me_sel;
  logic kill;
  logic arith;
  logic [`RSMU_W-1:0] rot_val;
  logic [`RSMU_W-1:0] mask_raw;
  logic [`RSMU_W-1:0] mask_eff;
  logic sign_fill;
  logic [`RSMU_W-1:0] res_calc;
  logic carry_calc;
  logic [3:0] cond_calc;

  // left rotation toward bit 0, the most significant position
  function automatic logic [`RSMU_W-1:0] rotate_fn(input logic [`RSMU_W-1:0] x,
    input logic [`RSMU_CNT_W-1:0] n);
    logic [2*`RSMU_W-1:0] d;
    d = {x, x} << n;
    return d[2*`RSMU_W-1:`RSMU_W];
  endfunction

  // accept ops only while software leaves the unit enabled
  assign op_ready_out = st_reg.enable;
  assign op_fire = op_valid_in & st_reg.enable;

  // amount register bits 27:31 and 26 sit at vector bits 4:0 and 5
  assign amt_lo = amount_gpr_in[`RSMU_CNT_W-1:0];
  assign amt_kill = amount_gpr_in[`RSMU_AMT_KILL];

  // pick rotate count and mask limits per operation
  always_comb begin
    rot_n = '0;
    mb_sel = `RSMU_BIT_FIRST;
    me_sel = `RSMU_BIT_LAST;
    kill = 1'b0;
    arith = 1'b0;
    case (op_code_in)
      RSMU_OP_ROT_VAR: begin
        rot_n = amt_lo;
        mb_sel = mask_begin_in;
        me_sel = mask_end_in;
      end
      RSMU_OP_ROT_IMM: begin
        rot_n = imm_count_in;
        mb_sel = mask_begin_in;
        me_sel = mask_end_in;
      end
      RSMU_OP_SHL_VAR: begin
        rot_n = amt_lo;
        me_sel = `RSMU_BIT_LAST - amt_lo;
        kill = amt_kill;
      end
      RSMU_OP_SHR_VAR: begin
        rot_n = `RSMU_BIT_FIRST - amt_lo;
        mb_sel = amt_lo;
        kill = amt_kill;
      end
      RSMU_OP_SRA_VAR: begin
        rot_n = `RSMU_BIT_FIRST - amt_lo;
        mb_sel = amt_lo;
        kill = amt_kill;
        arith = 1'b1;
      end
      RSMU_OP_SRA_IMM: begin
        rot_n = `RSMU_BIT_FIRST - imm_count_in;
        mb_sel = imm_count_in;
        arith = 1'b1;
      end
      default: begin
        kill = 1'b1;
      end
    endcase
  end

  // shared mask generator
  rsmu_mask_gen rsmu_mask_gen_i (
    .mask_begin_in(mb_sel),
    .mask_end_in(me_sel),
    .mask_out(mask_raw)
  );

  // rotate, mask, sign fill and carry out
  always_comb begin
    rot_val = rotate_fn(source_gpr_in, rot_n);
    mask_eff = kill ? '0 : mask_raw;
    sign_fill = arith & source_gpr_in[`RSMU_W-1];
    res_calc = (rot_val & mask_eff) | ({`RSMU_W{sign_fill}} & ~mask_eff);
    carry_calc = sign_fill & (|(rot_val & ~mask_eff));
  end

  // signed classification of the result plus summary overflow
  always_comb begin
    cond_calc = '0;
    cond_calc[`RSMU_CR_LT] = res_calc[`RSMU_W-1];
    cond_calc[`RSMU_CR_GT] = ~res_calc[`RSMU_W-1] & (|res_calc);
    cond_calc[`RSMU_CR_EQ] = ~(|res_calc);
    cond_calc[`RSMU_CR_SO] = st_reg.so;
  end

  // next state: op results, register writes, register reads
  always_comb begin
    st_next = st_reg;
    st_next.res_valid = 1'b0;
    st_next.cond_wr = 1'b0;
    st_next.carry_wr = 1'b0;
    st_next.rd_data = '0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `RSMU_REG_CTRL: st_next.enable = reg_wdata_in[`RSMU_CTRL_EN];
        `RSMU_REG_FXSTAT: begin
          st_next.so = reg_wdata_in[`RSMU_FX_SO];
          st_next.carry = reg_wdata_in[`RSMU_FX_CARRY];
        end
        default: st_next.enable = st_reg.enable;
      endcase
    end
    // an algebraic shift in the same cycle overrides a software carry write
    if (op_fire) begin
      st_next.result = res_calc;
      st_next.res_valid = 1'b1;
      st_next.opcnt = st_reg.opcnt + 1'b1;
      if (arith) begin
        st_next.carry = carry_calc;
        st_next.carry_wr = 1'b1;
      end
      if (record_bit_in) begin
        st_next.cond = cond_calc;
        st_next.cond_wr = 1'b1;
      end
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `RSMU_REG_CTRL: st_next.rd_data[`RSMU_CTRL_EN] = st_reg.enable;
        `RSMU_REG_FXSTAT: begin
          st_next.rd_data[`RSMU_FX_SO] = st_reg.so;
          st_next.rd_data[`RSMU_FX_CARRY] = st_reg.carry;
        end
        `RSMU_REG_RESULT: st_next.rd_data = st_reg.result;
        `RSMU_REG_COND: st_next.rd_data[3:0] = st_reg.cond;
        `RSMU_REG_OPCNT: st_next.rd_data[`RSMU_OPCNT_W-1:0] = st_reg.opcnt;
        default: st_next.rd_data = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '{enable: `RSMU_CTRL_EN_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state
  assign dest_gpr_out = st_reg.result;
  assign dest_wr_out = st_reg.res_valid;
  assign cond_field_zero_out = st_reg.cond;
  assign cond_wr_out = st_reg.cond_wr;
  assign algebraic_out_flag_out = st_reg.carry;
  assign carry_wr_out = st_reg.carry_wr;
  assign reg_rdata_out = st_reg.rd_data;

  // reference values sampled by the checks below
  logic [`RSMU_W-1:0] chk_rot;
  logic [`RSMU_W-1:0] chk_shl;
  logic [`RSMU_W-1:0] chk_shr;
  logic [`RSMU_W-1:0] chk_sra;
  logic [`RSMU_W-1:0] chk_lowmask;
  logic chk_carry;
  logic [`RSMU_W-1:0] chk_rot_imm;
  logic [`RSMU_W-1:0] chk_shr_var;
  logic [`RSMU_W-1:0] chk_sra_var;
  logic [`RSMU_W-1:0] chk_varmask;
  logic chk_carry_var;
  logic [`RSMU_W-1:0] chk_hi;
  logic [`RSMU_W-1:0] chk_lo;
  logic [`RSMU_W-1:0] chk_mask;
  always_comb begin
    chk_rot = rotate_fn(source_gpr_in, amt_lo);
    chk_shl = source_gpr_in << amt_lo;
    chk_shr = source_gpr_in >> mask_begin_in;
    chk_sra = $signed(source_gpr_in) >>> imm_count_in;
    chk_lowmask = ~({`RSMU_W{1'b1}} << imm_count_in);
    chk_carry = source_gpr_in[`RSMU_W-1] & (|(source_gpr_in & chk_lowmask));
    chk_rot_imm = rotate_fn(source_gpr_in, imm_count_in);
    chk_shr_var = source_gpr_in >> amt_lo;
    chk_sra_var = $signed(source_gpr_in) >>> amt_lo;
    chk_varmask = ~({`RSMU_W{1'b1}} << amt_lo);
    chk_carry_var = source_gpr_in[`RSMU_W-1] & (|(source_gpr_in & chk_varmask));
  end

  // mask reference from two shifted runs of ones, apart from the generator
  always_comb begin
    chk_hi = {`RSMU_W{1'b1}} >> mask_begin_in;
    chk_lo = {`RSMU_W{1'b1}} << (`RSMU_BIT_LAST - mask_end_in);
    chk_mask = (mask_begin_in > mask_end_in) ? (chk_hi | chk_lo) : (chk_hi & chk_lo);
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  AST_ROT_PLAIN: assert property (
    op_fire && op_code_in == RSMU_OP_ROT_VAR && mask_begin_in == `RSMU_BIT_FIRST
      && mask_end_in == `RSMU_BIT_LAST |=> dest_wr_out && dest_gpr_out == $past(chk_rot))
    else $error("plain rotation result wrong");
  AST_SRW_ALIAS: assert property (
    op_fire && op_code_in == RSMU_OP_ROT_IMM && mask_end_in == `RSMU_BIT_LAST
      && imm_count_in == `RSMU_BIT_FIRST - mask_begin_in |=> dest_gpr_out == $past(chk_shr))
    else $error("immediate right shift alias wrong");
  AST_SHL_VAL: assert property (
    op_fire && op_code_in == RSMU_OP_SHL_VAR && !amt_kill |=> dest_gpr_out == $past(chk_shl))
    else $error("left shift result wrong");
  AST_SHL_KILL: assert property (
    op_fire && op_code_in == RSMU_OP_SHL_VAR && amt_kill |=> dest_wr_out && dest_gpr_out == '0)
    else $error("left shift with bit 26 not zero");
  AST_SHR_KILL: assert property (
    op_fire && op_code_in == RSMU_OP_SHR_VAR && amt_kill |=> dest_gpr_out == '0)
    else $error("right shift with bit 26 not zero");
  AST_SRA_VAL: assert property (
    op_fire && op_code_in == RSMU_OP_SRA_IMM |=> dest_gpr_out == $past(chk_sra))
    else $error("algebraic shift result wrong");
  AST_SRA_CARRY: assert property (
    op_fire && op_code_in == RSMU_OP_SRA_IMM
      |=> carry_wr_out && algebraic_out_flag_out == $past(chk_carry))
    else $error("algebraic carry wrong");
  AST_SRA_BIG: assert property (
    op_fire && op_code_in == RSMU_OP_SRA_VAR && amt_kill |=>
      dest_gpr_out == {`RSMU_W{$past(source_gpr_in[`RSMU_W-1])}}
      && algebraic_out_flag_out == $past(source_gpr_in[`RSMU_W-1]))
    else $error("algebraic shift with bit 26 wrong");
  AST_WRAP_ENDS: assert property (
    op_fire && op_code_in == RSMU_OP_ROT_IMM && imm_count_in == '0
      && mask_begin_in > mask_end_in |=> dest_gpr_out[`RSMU_W-1] == $past(source_gpr_in[`RSMU_W-1])
      && dest_gpr_out[0] == $past(source_gpr_in[0]))
    else $error("wrapped mask ends not kept");
  AST_COND_SET: assert property (
    op_fire && record_bit_in |=> cond_wr_out
      && cond_field_zero_out[`RSMU_CR_EQ] == (dest_gpr_out == '0)
      && cond_field_zero_out[`RSMU_CR_LT] == dest_gpr_out[`RSMU_W-1])
    else $error("condition field not updated");
  AST_COND_SO: assert property (
    op_fire && record_bit_in |=> cond_field_zero_out[`RSMU_CR_SO] == $past(st_reg.so))
    else $error("summary overflow not copied");
  AST_COND_HOLD: assert property (
    !(op_fire && record_bit_in) |=> !cond_wr_out && $stable(cond_field_zero_out))
    else $error("condition field changed without record bit");
  AST_COND_GT: assert property (
    op_fire && record_bit_in
      |=> cond_field_zero_out[`RSMU_CR_GT] == (!dest_gpr_out[`RSMU_W-1] && dest_gpr_out != '0))
    else $error("greater-than bit wrong");

  // generated mask against the reference, plain and wrapped runs
  AST_MASK_RUN: assert property (
    op_fire && (op_code_in == RSMU_OP_ROT_VAR || op_code_in == RSMU_OP_ROT_IMM)
      && mask_begin_in <= mask_end_in |-> mask_raw == chk_mask)
    else $error("mask run wrong");
  AST_MASK_WRAP: assert property (
    op_fire && (op_code_in == RSMU_OP_ROT_VAR || op_code_in == RSMU_OP_ROT_IMM)
      && mask_begin_in > mask_end_in |-> mask_raw == chk_mask)
    else $error("wrapped mask wrong");

  // rotate-and-mask results, variable and immediate count
  AST_ROT_VAR_VAL: assert property (
    op_fire && op_code_in == RSMU_OP_ROT_VAR
      |=> dest_wr_out && dest_gpr_out == $past(chk_rot & chk_mask))
    else $error("variable rotate and mask result wrong");
  AST_ROT_IMM_VAL: assert property (
    op_fire && op_code_in == RSMU_OP_ROT_IMM
      |=> dest_wr_out && dest_gpr_out == $past(chk_rot_imm & chk_mask))
    else $error("immediate rotate and mask result wrong");

  // vacated positions of the logical shifts hold zeros
  AST_SHL_FILL: assert property (
    op_fire && op_code_in == RSMU_OP_SHL_VAR && !amt_kill
      |=> (dest_gpr_out & ~({`RSMU_W{1'b1}} << $past(amt_lo))) == '0)
    else $error("left shift fill not zero");
  AST_SHR_FILL: assert property (
    op_fire && op_code_in == RSMU_OP_SHR_VAR && !amt_kill
      |=> (dest_gpr_out & ~({`RSMU_W{1'b1}} >> $past(amt_lo))) == '0)
    else $error("right shift fill not zero");
  AST_SHR_VAL: assert property (
    op_fire && op_code_in == RSMU_OP_SHR_VAR && !amt_kill |=> dest_gpr_out == $past(chk_shr_var))
    else $error("right shift result wrong");

  // variable algebraic shift below the bit 26 limit
  AST_SRA_VAR_VAL: assert property (
    op_fire && op_code_in == RSMU_OP_SRA_VAR && !amt_kill |=> dest_gpr_out == $past(chk_sra_var))
    else $error("variable algebraic shift result wrong");
  AST_SRA_VAR_CARRY: assert property (
    op_fire && op_code_in == RSMU_OP_SRA_VAR && !amt_kill
      |=> carry_wr_out && algebraic_out_flag_out == $past(chk_carry_var))
    else $error("variable algebraic carry wrong");

  // carry left alone unless an algebraic shift or software writes it
  AST_CARRY_KEEP: assert property (
    op_fire && !arith && !reg_wr_in |=> !carry_wr_out && $stable(algebraic_out_flag_out))
    else $error("carry flag touched by a non-algebraic op");

  // vector bit 0 is the architectural lsb, so it lands at index n
  AST_BIT_ORDER: assert property (
    op_fire && op_code_in == RSMU_OP_SHL_VAR && !amt_kill
      |=> dest_gpr_out[$past(amt_lo)] == $past(source_gpr_in[0]))
    else $error("bit numbering wrong");

  // result and its strobe move only with an accepted op
  AST_RES_HOLD: assert property (
    !op_fire |=> !dest_wr_out && $stable(dest_gpr_out))
    else $error("result changed without an op");

  COV_ROT_WRAP: cover property (op_fire && op_code_in == RSMU_OP_ROT_VAR && mask_begin_in > mask_end_in);
  COV_SRA_CARRY: cover property (op_fire && op_code_in == RSMU_OP_SRA_VAR ##1 algebraic_out_flag_out);
  COV_SHL_KILL: cover property (op_fire && op_code_in == RSMU_OP_SHL_VAR && amt_kill);
  COV_RECORD: cover property (op_fire && record_bit_in ##1 op_fire && record_bit_in);
  COV_ROT_IMM_WRAP: cover property (op_fire && op_code_in == RSMU_OP_ROT_IMM && mask_begin_in > mask_end_in);
endmodule

//--- design/rsmu_mask_gen.sv
// mask generator: ones from begin through end, wrapping when begin follows end
// assumes bit 0 is the most significant position of the word
`include "rsmu_cfg.svh"
module rsmu_mask_gen (
  input wire logic [`RSMU_CNT_W-1:0] mask_begin_in,
  input wire logic [`RSMU_CNT_W-1:0] mask_end_in,
  output logic [`RSMU_W-1:0] mask_out
);
  import rsmu_pkg::*;
  logic wrap;
  // begin after end means the ones run through bit 31 back to bit 0
  assign wrap = (mask_begin_in > mask_end_in);
  // one compare pair per bit, vector index j is position 31-j
  for (genvar j = 0; j < `RSMU_W; j++) begin : g_bit
    localparam logic [`RSMU_CNT_W-1:0] POS = `RSMU_BIT_LAST - 5'(j);
    logic ge_b;
    logic le_e;
    assign ge_b = (POS >= mask_begin_in);
    assign le_e = (POS <= mask_end_in);
    assign mask_out[j] = wrap ? (ge_b | le_e) : (ge_b & le_e);
  end
endmodule

//--- inc/rsmu_cfg.svh
// constants of the rotate, shift and mask unit
// assumes one 25 MHz core clock and a decode stage that issues one op per cycle
// How it works
// - variable rotate uses amount low five bits
// - mask ones from begin through end inclusive
// - begin after end wraps mask ones around
// - variable rotate writes rotated AND mask
// - record bit updates condition field zero
// - mask 0 to 31 gives plain rotation
// - immediate right shift equals rotate mask alias
// - left shift discards top, zero fills right
// - left shift amount bit 26 gives zero
// - right shift discards bottom, zero fills left
// - right shift amount bit 26 gives zero
// - algebraic shift fills with source sign bit
// - carry set when negative and ones lost
// - algebraic bit 26 copies sign everywhere, carry
// - immediate algebraic shift uses immediate count
// - immediate rotate then AND with mask
`ifndef RSMU_CFG_SVH
`define RSMU_CFG_SVH
`define RSMU_W 32
`define RSMU_CNT_W 5
`define RSMU_BIT_LAST 5'h1f
`define RSMU_BIT_FIRST 5'h00
`define RSMU_AMT_KILL 5
`define RSMU_AW 8
`define RSMU_OPCNT_W 16
`define RSMU_REG_CTRL 8'h00
`define RSMU_REG_FXSTAT 8'h04
`define RSMU_REG_RESULT 8'h08
`define RSMU_REG_COND 8'h0c
`define RSMU_REG_OPCNT 8'h10
`define RSMU_CTRL_EN 0
`define RSMU_CTRL_EN_RST 1'b1
`define RSMU_FX_SO 0
`define RSMU_FX_CARRY 1
`define RSMU_CR_LT 3
`define RSMU_CR_GT 2
`define RSMU_CR_EQ 1
`define RSMU_CR_SO 0
`endif

//--- inc/rsmu_pkg.sv
// types of the rotate, shift and mask unit
// assumes rsmu_cfg.svh is on the include path
`include "rsmu_cfg.svh"
package rsmu_pkg;
  // operations issued by decode
  typedef enum logic [2:0] {
    RSMU_OP_ROT_VAR = 3'h0,
    RSMU_OP_ROT_IMM = 3'h1,
    RSMU_OP_SHL_VAR = 3'h2,
    RSMU_OP_SHR_VAR = 3'h3,
    RSMU_OP_SRA_VAR = 3'h4,
    RSMU_OP_SRA_IMM = 3'h5
  } rsmu_op_e;
  // whole state of the core
  typedef struct packed {
    logic enable;
    logic so;
    logic carry;
    logic [`RSMU_W-1:0] result;
    logic [3:0] cond;
    logic res_valid;
    logic cond_wr;
    logic carry_wr;
    logic [`RSMU_OPCNT_W-1:0] opcnt;
    logic [`RSMU_W-1:0] rd_data;
  } rsmu_state_s;
endpackage

//--- tb/rotate_shift_mask_unit_tb.sv
// self-checking bench of the rotate, shift and mask unit
// assumes rsmu_pkg compiled first and rsmu_cfg.svh on the include path
`include "rsmu_cfg.svh"
module rotate_shift_mask_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsmu_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, vld = 1'h0, rec = 1'h0, wr = 1'h0, rd = 1'h0, e_so = 1'h0;
  rsmu_op_e opc = RSMU_OP_ROT_VAR;
  logic [31:0] src = 32'h0, amt = 32'h0, wdat = 32'h0, dst, rdat, wb_gpr;
  logic [4:0] imm = 5'h0, mb = 5'h0, me = 5'h0;
  logic [7:0] addr = 8'h0;
  logic rdy, dwr, cwr, caf, cawr;
  logic [3:0] cond;
  logic [15:0] wb_cnt;
  int errors = 0, checked = 0, cyc = 0, n_ops = 0;
  rsmu_core rsmu_core_i (.clk_sys_in(clk), .rstn_in(rstn), .op_valid_in(vld), .op_code_in(opc),
    .source_gpr_in(src), .amount_gpr_in(amt), .imm_count_in(imm), .mask_begin_in(mb), .mask_end_in(me),
    .record_bit_in(rec), .op_ready_out(rdy), .dest_gpr_out(dst), .dest_wr_out(dwr),
    .cond_field_zero_out(cond), .cond_wr_out(cwr), .algebraic_out_flag_out(caf), .carry_wr_out(cawr),
    .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat));
  rsmu_wb_model rsmu_wb_model_i (.clk_in(clk), .rstn_in(rstn), .wr_in(dwr), .data_in(dst),
    .gpr_out(wb_gpr), .wr_cnt_out(wb_cnt));
  // 25 MHz clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      $display("MISMATCH %0t run hung", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // mask in msb-first numbering, wrapping when begin follows end
  function automatic logic [31:0] msk(input logic [4:0] b, input logic [4:0] e);
    for (int i = 0; i < 32; i++) msk[31-i] = (b <= e) ? (i >= b && i <= e) : (i >= b || i <= e);
  endfunction
  function automatic logic [31:0] rotate_fn(input logic [31:0] x, input logic [4:0] n);
    logic [63:0] t;
    t = {x, x} << n;
    return t[63:32];
  endfunction
  // one op, result judged the cycle after it is taken
  task automatic do_op(input rsmu_op_e o, input logic [31:0] s, input logic [31:0] a, input logic [4:0] i,
                       input logic [4:0] b, input logic [4:0] e, input logic r);
    logic [4:0] n;
    logic [31:0] x;
    logic c, sra;
    n = (o == RSMU_OP_SRA_IMM || o == RSMU_OP_ROT_IMM) ? i : a[4:0];
    sra = (o == RSMU_OP_SRA_VAR || o == RSMU_OP_SRA_IMM);
    c = 1'h0;
    case (o)
      RSMU_OP_ROT_VAR, RSMU_OP_ROT_IMM: x = rotate_fn(s, n) & msk(b, e);
      RSMU_OP_SHL_VAR: x = a[5] ? 32'h0 : s << n;
      RSMU_OP_SHR_VAR: x = a[5] ? 32'h0 : s >> n;
      default: begin
        x = (a[5] && o == RSMU_OP_SRA_VAR) ? {32{s[31]}} : 32'($signed(s) >>> n);
        c = (a[5] && o == RSMU_OP_SRA_VAR) ? s[31] : s[31] && ((s & ~(32'hffffffff << n)) != 32'h0);
      end
    endcase
    @(posedge clk);
    vld <= 1'h1; opc <= o; src <= s; amt <= a; imm <= i; mb <= b; me <= e; rec <= r;
    @(posedge clk);
    vld <= 1'h0;
    n_ops++;
    #1;
    chk(dst, x, "result");
    chk(32'(dwr), 32'h1, "dest write");
    chk(32'(cwr), 32'(r), "cond write");
    if (r) chk(32'(cond), {28'h0, x[31], !x[31] && x != 32'h0, x == 32'h0, e_so}, "cond");
    chk(32'(cawr), 32'(sra), "carry write");
    if (sra) chk(32'(caf), 32'(c), "carry");
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1; addr <= a; wdat <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1; addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(rdat, e, "reg read");
  endtask
  // reset values
  task automatic t_reset();
    #1;
    chk(32'(rdy), 32'h1, "ready");
    chk(dst, 32'h0, "dest at reset");
    reg_rd(`RSMU_REG_CTRL, 32'h1);
    reg_rd(`RSMU_REG_FXSTAT, 32'h0);
  endtask
  // rotate with plain, wrapped and alias masks
  task automatic t_rotate();
    do_op(RSMU_OP_ROT_VAR, 32'h12345678, 32'hffffffe4, 5'h0, 5'h0, 5'h1f, 1'h1);
    do_op(RSMU_OP_ROT_VAR, 32'h9abcdef1, 32'h3, 5'h0, 5'h1c, 5'h3, 1'h0);
    do_op(RSMU_OP_ROT_IMM, 32'hcafe0f0f, 32'h0, 5'h8, 5'h4, 5'h13, 1'h0);
    do_op(RSMU_OP_ROT_IMM, 32'hf000000f, 32'h0, 5'h0, 5'h1e, 5'h1, 1'h0);
    do_op(RSMU_OP_ROT_IMM, 32'hf0000081, 32'h0, 5'h18, 5'h8, 5'h1f, 1'h0);
    do_op(RSMU_OP_SHR_VAR, 32'hf0000081, 32'h8, 5'h0, 5'h0, 5'h0, 1'h0);
  endtask
  // logical and algebraic shifts, bit 26 and carry cases
  task automatic t_shift();
    do_op(RSMU_OP_SHL_VAR, 32'h80000001, 32'h1f, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SHL_VAR, 32'hffffffff, 32'h21, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SHR_VAR, 32'h80000001, 32'h1, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SHR_VAR, 32'hffffffff, 32'h20, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SRA_VAR, 32'h80000003, 32'h1, 5'h0, 5'h0, 5'h0, 1'h1);
    do_op(RSMU_OP_SRA_VAR, 32'h70000003, 32'h4, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SRA_VAR, 32'h80000000, 32'h20, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SRA_VAR, 32'h7fffffff, 32'h3f, 5'h0, 5'h0, 5'h0, 1'h0);
    do_op(RSMU_OP_SRA_IMM, 32'h80000003, 32'h21, 5'h1, 5'h9, 5'h0, 1'h0);
    do_op(RSMU_OP_SRA_IMM, 32'h80000001, 32'h0, 5'h0, 5'h0, 5'h0, 1'h0);
  endtask
  // summary overflow copied into the condition field
  task automatic t_cond();
    reg_wr(`RSMU_REG_FXSTAT, 32'h1);
    e_so = 1'h1;
    do_op(RSMU_OP_SHL_VAR, 32'h0, 32'h3, 5'h0, 5'h0, 5'h0, 1'h1);
    do_op(RSMU_OP_SHR_VAR, 32'h40, 32'h2, 5'h0, 5'h0, 5'h0, 1'h1);
    reg_wr(`RSMU_REG_FXSTAT, 32'h0);
    e_so = 1'h0;
    do_op(RSMU_OP_ROT_VAR, 32'h1, 32'h1f, 5'h0, 5'h0, 5'h1f, 1'h1);
    reg_rd(`RSMU_REG_COND, 32'h8);
  endtask
  // back-to-back ops, refused op, counters and unmapped read
  task automatic t_flow();
    @(posedge clk);
    vld <= 1'h1; opc <= RSMU_OP_SHL_VAR; src <= 32'h1; amt <= 32'h1; rec <= 1'h0;
    @(posedge clk);
    opc <= RSMU_OP_SHR_VAR; src <= 32'h8;
    #1;
    chk(dst, 32'h2, "first of pair");
    @(posedge clk);
    vld <= 1'h0;
    n_ops += 2;
    #1;
    chk(dst, 32'h4, "second of pair");
    reg_wr(`RSMU_REG_CTRL, 32'h0);
    #1;
    chk(32'(rdy), 32'h0, "not ready");
    @(posedge clk);
    vld <= 1'h1; opc <= RSMU_OP_SHL_VAR; src <= 32'hff;
    @(posedge clk);
    vld <= 1'h0;
    #1;
    chk(32'(dwr), 32'h0, "refused op written");
    reg_wr(`RSMU_REG_CTRL, 32'h1);
    reg_rd(`RSMU_REG_RESULT, 32'h4);
    reg_rd(`RSMU_REG_OPCNT, 32'(n_ops));
    chk(32'(wb_cnt), 32'(n_ops), "writebacks");
    chk(wb_gpr, 32'h4, "last writeback");
    reg_rd(8'h14, 32'h0);
    // an op code outside the six decoded ones gives zero and no carry
    @(posedge clk);
    vld <= 1'h1; opc <= rsmu_op_e'(3'h6); src <= 32'hffffffff;
    @(posedge clk);
    vld <= 1'h0;
    #1;
    chk(dst, 32'h0, "unused op code result");
    chk(32'(cawr), 32'h0, "unused op code carry write");
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_reset();
    t_rotate();
    t_shift();
    t_cond();
    t_flow();
    end_sim();
  end
endmodule

//--- tb/rsmu_wb_model.sv
// register file side: catches every result the unit writes back
// assumes one dest write pulse per accepted op, core clock only
`include "rsmu_cfg.svh"
module rsmu_wb_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic [`RSMU_W-1:0] data_in,
  output logic [`RSMU_W-1:0] gpr_out,
  output logic [15:0] wr_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // latch written value, count writes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gpr_out <= 32'h0;
      wr_cnt_out <= 16'h0;
    end else if (wr_in) begin
      gpr_out <= data_in;
      wr_cnt_out <= wr_cnt_out + 16'h1;
    end
  end
endmodule
